/* File: include/fci_consts.svh */
`ifndef FCI_CONSTS_SVH
`define FCI_CONSTS_SVH

// request command codes
`define FCI_CMD_FLUSH 8'h06
`define FCI_CMD_INFO 8'h07
`define FCI_CMD_SEEK 8'h08
`define FCI_CMD_DELETE 8'h09
`define FCI_CMD_MKDIR 8'h0a
`define FCI_CMD_LIST 8'h0b
`define FCI_CMD_CARD 8'h0c
`define FCI_CMD_CAPACITY 8'h0d

// reply forming
`define FCI_REPLY_BIT 8'h80
`define FCI_CMD_ERROR 8'h7f

// error codes placed in the handle/option field
`define FCI_ERR_HANDLE 8'h03
`define FCI_ERR_LENGTH 8'h0f
`define FCI_ERR_PACKET 8'h10
`define FCI_ERR_NO_CARD 8'h11
`define FCI_ERR_UNKNOWN 8'h13

// lengths, in bytes
`define FCI_HDR_BYTES 16'h0004
`define FCI_PATH_MAX 16'h0200
`define FCI_SEEK_LEN 16'h0004
`define FCI_WORDS_LEN 16'h0008
`define FCI_CARD_LEN 16'h0001

// listing name decoration
`define FCI_CHAR_OPEN 8'h3c
`define FCI_CHAR_CLOSE 8'h3e
`define FCI_CHAR_NUL 8'h00

`endif

/* File: include/fci_pkg.sv */
package fci_pkg;

    typedef enum logic [2:0] {
        FCI_ST_CMD,
        FCI_ST_OPT,
        FCI_ST_LENL,
        FCI_ST_LENH,
        FCI_ST_PAY,
        FCI_ST_CHECK,
        FCI_ST_WAIT,
        FCI_ST_TX
    } fci_state_e;

    typedef struct packed {
        fci_state_e st;
        logic [7:0] cmd;
        logic [7:0] opt;
        logic [15:0] len;
        logic [15:0] cnt;
        logic fwd;
        logic [31:0] arg;
        logic rewind;
        logic be_req;
        logic [7:0] rcode;
        logic [7:0] ropt;
        logic [15:0] rlen;
        logic [31:0] w0;
        logic [31:0] w1;
        logic is_list;
        logic is_dir;
        logic [9:0] nlen;
        logic [15:0] tpos;
        logic tx_full;
        logic tx_last;
        logic [7:0] tx_data;
    } fci_regs_s;

endpackage

/* File: rtl/fci_reply_byte.sv */
`timescale 1ns/1ps
`include "fci_consts.svh"

// picks the reply byte at a given position; listing names come from outside
module fci_reply_byte
    import fci_pkg::*;
(
    input wire logic [15:0] pos, // byte position within the reply
    input wire logic [7:0] rcode, // reply command code
    input wire logic [7:0] ropt, // reply handle/option byte
    input wire logic [15:0] rlen, // reply data length
    input wire logic [31:0] w0, // first payload word
    input wire logic [31:0] w1, // second payload word
    input wire logic is_list, // payload is a listing entry
    input wire logic is_dir, // listing entry is a directory
    input wire logic [9:0] nlen, // entry name length, no terminator
    output logic [7:0] byte_out, // byte for non-name positions
    output logic is_name // position holds an entry name character
);
    logic [15:0] p;
    logic [15:0] nstart;
    logic [15:0] nend;
    logic [31:0] word;

    assign p = pos - `FCI_HDR_BYTES;
    assign nstart = is_dir ? 16'h0001 : 16'h0000;
    assign nend = nstart + {6'h00, nlen};
    assign word = p[2] ? w1 : w0;

    // header, then little-endian words or a decorated listing name
    always_comb begin
        is_name = 1'b0;
        byte_out = `FCI_CHAR_NUL;
        if (pos < `FCI_HDR_BYTES) begin
            case (pos[1:0])
                2'h0: byte_out = rcode;
                2'h1: byte_out = ropt;
                2'h2: byte_out = rlen[7:0];
                default: byte_out = rlen[15:8];
            endcase
        end else if (!is_list) begin
            byte_out = word[8 * p[1:0] +: 8]; // R19
        end else if (is_dir && p == 16'h0000) begin
            byte_out = `FCI_CHAR_OPEN; // R12
        end else if (p < nend) begin
            is_name = 1'b1;
        end else if (is_dir && p == nend) begin
            byte_out = `FCI_CHAR_CLOSE; // R12
        end else begin
            byte_out = `FCI_CHAR_NUL;
        end
    end
endmodule

/* File: rtl/fci_file_cmd.sv */
`timescale 1ns/1ps
`include "fci_consts.svh"

// Operation
// (R01) flush 0x06 with open handle; success reply 0x86 echoes the handle
// (R02) file info 0x07 carries a handle and no payload
// (R03) info reply 0x87, handle, 8 bytes: pointer position then file length
// (R04) seek 0x08 with handle and 4-byte position; reply 0x88 with new position
// (R05) seeking past the end extends the file; added bytes are unspecified
// (R06) delete 0x09 takes a null-terminated path up to 512 bytes; reply 0x89
// (R07) delete fails if target missing, in use, or a non-empty directory
// (R08) mkdir 0x0a takes a null-terminated path up to 512 bytes; reply 0x8a
// (R09) listing 0x0b returns one null-terminated entry per reply 0x8b
// (R10) after the last entry, listing reply has zero length and no payload
// (R11) listing request of zero length restarts the listing from the first entry
// (R12) directory names are enclosed in angle brackets, file names are not
// (R13) card query 0x0c replies 0x8c with one byte: 1 present, 0 absent
// (R14) capacity 0x0d replies 0x8d with 8 bytes: total then free space
// (R15) any failure replies 0x7f with the error code in the option field
// (R16) a handle not naming an open file gives error code 3
// (R17) a media command with no card inserted gives error code 17
// (R18) success code is request code with top bit set; one reply per request
// (R19) multi-byte fields are little-endian in requests and replies
module fci_file_cmd
    import fci_pkg::*;
#(
    parameter int NUM_HANDLES = 4
) (
    input wire logic core_clk, // system clock, 200 MHz
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic rx_valid, // request byte valid (framing removed)
    input wire logic [7:0] rx_data, // request byte
    output logic rx_ready, // request byte taken when valid and ready
    output logic tx_valid, // reply byte valid
    output logic [7:0] tx_data, // reply byte
    output logic tx_last, // last byte of the reply packet
    input wire logic tx_ready, // reply byte taken when valid and ready
    input wire logic card_present, // card sits in the slot
    input wire logic [NUM_HANDLES-1:0] handle_open, // one bit per open handle
    output logic be_req, // back-end operation request, held until done
    output logic [7:0] be_cmd, // request code of the operation
    output logic [7:0] be_handle, // handle of the operation
    output logic [31:0] be_arg, // seek position
    output logic be_rewind, // listing request restarts the sequence
    output logic be_path_valid, // path byte to back end
    output logic [7:0] be_path_data, // path byte
    output logic be_path_last, // last path byte
    input wire logic be_path_ready, // back end takes path byte
    input wire logic be_done, // operation finished, one-cycle pulse
    input wire logic [7:0] be_err, // error code, zero on success
    input wire logic [31:0] be_word0, // position / new position / total
    input wire logic [31:0] be_word1, // file length / free space
    input wire logic be_list_end, // no more entries in the listing
    input wire logic be_list_dir, // entry is a directory
    input wire logic [9:0] be_name_len, // entry name length, no terminator
    input wire logic be_name_valid, // entry name character valid
    input wire logic [7:0] be_name_data, // entry name character
    output logic be_name_ready // entry name character taken
);
    fci_regs_s s_reg;
    fci_regs_s s_next;
    logic take;
    logic slot;
    logic more;
    logic [15:0] total;
    logic [7:0] pick_byte;
    logic pick_name;
    logic [7:0] pre_err;
    logic need_handle;
    logic handle_ok;

    fci_reply_byte u_pick (
        .pos(s_reg.tpos),
        .rcode(s_reg.rcode),
        .ropt(s_reg.ropt),
        .rlen(s_reg.rlen),
        .w0(s_reg.w0),
        .w1(s_reg.w1),
        .is_list(s_reg.is_list),
        .is_dir(s_reg.is_dir),
        .nlen(s_reg.nlen),
        .byte_out(pick_byte),
        .is_name(pick_name)
    );

    // request-side handshake: path bytes wait for the back end
    always_comb begin
        case (s_reg.st)
            FCI_ST_CMD, FCI_ST_OPT, FCI_ST_LENL, FCI_ST_LENH: rx_ready = 1'b1;
            FCI_ST_PAY: rx_ready = s_reg.fwd ? be_path_ready : 1'b1;
            default: rx_ready = 1'b0;
        endcase
    end

    assign take = rx_valid && rx_ready;
    assign total = `FCI_HDR_BYTES + s_reg.rlen;
    assign slot = !s_reg.tx_full || tx_ready;
    assign more = s_reg.tpos < total;

    assign be_path_valid = s_reg.st == FCI_ST_PAY && s_reg.fwd && rx_valid;
    assign be_path_data = rx_data;
    assign be_path_last = s_reg.cnt == 16'h0001;
    assign be_name_ready = s_reg.st == FCI_ST_TX && slot && more && pick_name;
    assign be_req = s_reg.be_req;
    assign be_cmd = s_reg.cmd;
    assign be_handle = s_reg.opt;
    assign be_arg = s_reg.arg;
    assign be_rewind = s_reg.rewind;
    assign tx_valid = s_reg.st == FCI_ST_TX && s_reg.tx_full;
    assign tx_data = s_reg.tx_data;
    assign tx_last = s_reg.tx_last;

    // handle check: out-of-range handles count as closed
    assign need_handle = s_reg.cmd == `FCI_CMD_FLUSH || s_reg.cmd == `FCI_CMD_INFO // R02
        || s_reg.cmd == `FCI_CMD_SEEK;
    assign handle_ok = (s_reg.opt < 8'(NUM_HANDLES))
        && handle_open[s_reg.opt[$clog2(NUM_HANDLES)-1:0]];

    // checks made before the back end is asked; the order sets priority
    always_comb begin
        pre_err = 8'h00;
        case (s_reg.cmd)
            `FCI_CMD_FLUSH, `FCI_CMD_INFO, `FCI_CMD_SEEK, `FCI_CMD_DELETE,
            `FCI_CMD_MKDIR, `FCI_CMD_LIST, `FCI_CMD_CAPACITY, `FCI_CMD_CARD: begin
                if (s_reg.cmd != `FCI_CMD_CARD && !card_present) begin
                    pre_err = `FCI_ERR_NO_CARD; // R17
                end else if (need_handle && !handle_ok) begin
                    pre_err = `FCI_ERR_HANDLE; // R16
                end else if (s_reg.cmd == `FCI_CMD_SEEK && s_reg.len != `FCI_SEEK_LEN) begin
                    pre_err = `FCI_ERR_PACKET; // R04
                end else if ((s_reg.cmd == `FCI_CMD_DELETE || s_reg.cmd == `FCI_CMD_MKDIR)
                        && (s_reg.len == 16'h0000 || s_reg.len > `FCI_PATH_MAX)) begin
                    pre_err = `FCI_ERR_LENGTH; // R06 R08
                end else if (s_reg.cmd == `FCI_CMD_LIST && s_reg.len > `FCI_PATH_MAX) begin
                    pre_err = `FCI_ERR_LENGTH;
                end
            end
            default: pre_err = `FCI_ERR_UNKNOWN;
        endcase
    end

    // packet parse, back-end dispatch and reply streaming
    always_comb begin
        s_next = s_reg;
        case (s_reg.st)
            FCI_ST_CMD: begin
                if (take) begin
                    s_next.cmd = rx_data;
                    s_next.st = FCI_ST_OPT;
                end
            end
            FCI_ST_OPT: begin
                if (take) begin
                    s_next.opt = rx_data;
                    s_next.st = FCI_ST_LENL;
                end
            end
            FCI_ST_LENL: begin
                if (take) begin
                    s_next.len[7:0] = rx_data; // R19
                    s_next.st = FCI_ST_LENH;
                end
            end
            FCI_ST_LENH: begin
                if (take) begin
                    s_next.len = {rx_data, s_reg.len[7:0]};
                    s_next.cnt = {rx_data, s_reg.len[7:0]};
                    s_next.arg = 32'h0000_0000;
                    // over-long paths are drained, never handed on
                    s_next.fwd = (s_reg.cmd == `FCI_CMD_DELETE || s_reg.cmd == `FCI_CMD_MKDIR
                        || s_reg.cmd == `FCI_CMD_LIST) && s_next.len <= `FCI_PATH_MAX;
                    s_next.st = s_next.len == 16'h0000 ? FCI_ST_CHECK : FCI_ST_PAY;
                end
            end
            FCI_ST_PAY: begin
                if (take) begin
                    s_next.cnt = s_reg.cnt - 16'h0001;
                    if (s_reg.cmd == `FCI_CMD_SEEK) begin
                        s_next.arg = {rx_data, s_reg.arg[31:8]}; // R19
                    end
                    if (s_reg.cnt == 16'h0001) begin
                        s_next.st = FCI_ST_CHECK;
                    end
                end
            end
            FCI_ST_CHECK: begin
                s_next.rcode = s_reg.cmd | `FCI_REPLY_BIT; // R18
                s_next.ropt = need_handle ? s_reg.opt : 8'h00; // R01
                s_next.rlen = 16'h0000;
                s_next.is_list = 1'b0;
                s_next.rewind = s_reg.cmd == `FCI_CMD_LIST && s_reg.len == 16'h0000; // R11
                s_next.tpos = 16'h0000;
                s_next.tx_full = 1'b0;
                if (pre_err != 8'h00) begin
                    s_next.rcode = `FCI_CMD_ERROR; // R15
                    s_next.ropt = pre_err;
                    s_next.st = FCI_ST_TX;
                end else if (s_reg.cmd == `FCI_CMD_CARD) begin
                    s_next.rlen = `FCI_CARD_LEN; // R13
                    s_next.w0 = {31'h0000_0000, card_present};
                    s_next.st = FCI_ST_TX;
                end else begin
                    s_next.be_req = 1'b1;
                    s_next.st = FCI_ST_WAIT;
                end
            end
            FCI_ST_WAIT: begin
                if (be_done) begin
                    s_next.be_req = 1'b0;
                    s_next.st = FCI_ST_TX;
                    if (be_err != 8'h00) begin
                        s_next.rcode = `FCI_CMD_ERROR; // R07 R15
                        s_next.ropt = be_err;
                    end else begin
                        case (s_reg.cmd)
                            `FCI_CMD_INFO, `FCI_CMD_CAPACITY: begin
                                s_next.w0 = be_word0; // R03 R14
                                s_next.w1 = be_word1;
                                s_next.rlen = `FCI_WORDS_LEN;
                            end
                            `FCI_CMD_SEEK: begin
                                // the back end grows the file when the position is past its end
                                s_next.w0 = be_word0; // R04 R05
                                s_next.rlen = `FCI_SEEK_LEN;
                            end
                            `FCI_CMD_LIST: begin
                                if (!be_list_end && !s_reg.rewind) begin
                                    s_next.is_list = 1'b1; // R09
                                    s_next.is_dir = be_list_dir;
                                    s_next.nlen = be_name_len;
                                    s_next.rlen = {6'h00, be_name_len} + 16'h0001
                                        + (be_list_dir ? 16'h0002 : 16'h0000); // R12
                                end // R10
                            end
                            default: s_next.rlen = 16'h0000; // R06 R08
                        endcase
                    end
                end
            end
            FCI_ST_TX: begin
                // a name character that is late simply leaves a bubble
                if (slot) begin
                    if (more) begin
                        s_next.tx_last = s_reg.tpos == total - 16'h0001;
                        if (pick_name) begin
                            s_next.tx_full = be_name_valid;
                            s_next.tx_data = be_name_data;
                            if (be_name_valid) begin
                                s_next.tpos = s_reg.tpos + 16'h0001;
                            end
                        end else begin
                            s_next.tx_full = 1'b1;
                            s_next.tx_data = pick_byte;
                            s_next.tpos = s_reg.tpos + 16'h0001;
                        end
                    end else begin
                        s_next.tx_full = 1'b0; // R18
                        s_next.tx_last = 1'b0;
                        s_next.is_list = 1'b0;
                        s_next.st = FCI_ST_CMD;
                    end
                end
            end
            default: s_next.st = FCI_ST_CMD;
        endcase
    end

    // single state register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

/* File: tb/fci_file_cmd_props.sv */
`timescale 1ns/1ps

// port-level checks of back-end handshake and reply timing
module fci_file_cmd_props #(
    parameter int NUM_HANDLES = 4
) (
    input wire logic core_clk, // clock
    input wire logic sys_rst, // sync reset
    input wire logic rx_ready, // request byte taken
    input wire logic tx_valid, // reply byte valid
    input wire logic [7:0] tx_data, // reply byte
    input wire logic tx_last, // last reply byte
    input wire logic tx_ready, // reply sink ready
    input wire logic card_present, // card in slot
    input wire logic [NUM_HANDLES-1:0] handle_open, // open handles
    input wire logic be_req, // back-end request
    input wire logic [7:0] be_cmd, // operation code
    input wire logic [7:0] be_handle, // operation handle
    input wire logic [31:0] be_arg, // seek position
    input wire logic be_done, // operation finished
    input wire logic [7:0] be_err // operation error
);
    logic [7:0] cmd_seen_reg;

    // chk_req_hold only holds be_cmd stable while be_req is high, so the reply check keeps a copy
    always_ff @(posedge core_clk) begin
        if (be_req) begin
            cmd_seen_reg <= be_cmd;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    chk_req_hold:
    assert property (be_req && !be_done |=> be_req && $stable(be_cmd) && $stable(be_handle)
        && $stable(be_arg)) else $error("back-end request changed before done");
    chk_req_drop:
    assert property (be_req && be_done |=> !be_req) else $error("request kept after done");
    chk_reply_code:
    assert property (be_req && be_done && be_err == 8'h00 |-> ##[1:3] (tx_valid
        && tx_data == (cmd_seen_reg | 8'h80))) else $error("success code not sent");
    chk_error_code:
    assert property (be_req && be_done && be_err != 8'h00 |-> ##[1:3] (tx_valid
        && tx_data == 8'h7f)) else $error("error code not sent");
    chk_tx_hold:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("reply byte dropped before taken");
    chk_rx_refused:
    assert property (tx_valid |-> !rx_ready) else $error("request taken during reply");
    chk_card_local:
    assert property (be_req |-> be_cmd != 8'h0c) else $error("card query used back end");
    chk_card_needed:
    assert property ($rose(be_req) |-> card_present) else $error("media request with no card");
    chk_handle_open:
    assert property ($rose(be_req) && be_cmd inside {8'h06, 8'h07, 8'h08} |->
        be_handle < NUM_HANDLES && handle_open[be_handle]) else $error("closed handle passed");
endmodule

bind fci_file_cmd fci_file_cmd_props #(.NUM_HANDLES(NUM_HANDLES)) u_fci_file_cmd_props (
    .core_clk, .sys_rst, .rx_ready, .tx_valid, .tx_data, .tx_last, .tx_ready, .card_present,
    .handle_open, .be_req, .be_cmd, .be_handle, .be_arg, .be_done, .be_err);

/* File: tb/fci_backend_model.sv */
`timescale 1ns/1ps

// storage back end: one open file, a two-entry listing, fixed capacity
module fci_backend_model #(
    parameter logic [31:0] TOTAL_BYTES = 32'h0040_0000,
    parameter logic [31:0] FREE_BYTES = 32'h0000_2000
) (
    input wire logic core_clk, // clock
    input wire logic sys_rst, // sync reset
    input wire logic slow, // long latency and stalled bytes
    input wire logic [7:0] err_in, // error to return, zero for success
    input wire logic be_req, // operation request
    input wire logic [7:0] be_cmd, // operation code
    input wire logic [31:0] be_arg, // seek position
    input wire logic be_rewind, // listing restart
    output logic be_path_ready, // path byte taken
    output logic be_done, // finished pulse
    output logic [7:0] be_err, // error code
    output logic [31:0] be_word0, // first payload word
    output logic [31:0] be_word1, // second payload word
    output logic be_list_end, // listing exhausted
    output logic be_list_dir, // entry is a directory
    output logic [9:0] be_name_len, // entry name length
    output logic be_name_valid, // name char valid
    output logic [7:0] be_name_data, // name char
    input wire logic be_name_ready // name char taken
);
    logic [2:0] wait_reg;
    logic [31:0] pos_reg;
    logic [31:0] flen_reg;
    logic [1:0] idx_reg; // 0 dir "ab", 1 file "x", 2 end
    logic [1:0] sidx_reg;
    logic nidx_reg;
    logic stream_reg;
    logic tick_reg;
    logic [7:0] chr;

    // grown region after a seek is not filled: its contents are unspecified
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wait_reg <= 3'h0;
            pos_reg <= 32'h0000_0000;
            flen_reg <= 32'h0000_0100;
            idx_reg <= 2'h0;
            sidx_reg <= 2'h0;
            nidx_reg <= 1'b0;
            stream_reg <= 1'b0;
            tick_reg <= 1'b0;
            be_done <= 1'b0;
        end else begin
            tick_reg <= !tick_reg;
            be_done <= 1'b0;
            if (be_req && !be_done) begin
                wait_reg <= wait_reg + 3'h1;
                if (wait_reg == (slow ? 3'h6 : 3'h0)) begin
                    be_done <= 1'b1;
                    wait_reg <= 3'h0;
                end
            end
            if (be_done && err_in == 8'h00 && be_cmd == 8'h08) begin
                pos_reg <= be_arg;
                if (be_arg > flen_reg) begin
                    flen_reg <= be_arg;
                end
            end
            if (be_done && be_cmd == 8'h0b) begin
                idx_reg <= be_rewind ? 2'h0 : (idx_reg == 2'h2 ? 2'h2 : idx_reg + 2'h1);
                sidx_reg <= idx_reg;
                nidx_reg <= 1'b0;
                stream_reg <= !be_rewind && idx_reg != 2'h2;
            end
            if (be_name_valid && be_name_ready) begin
                nidx_reg <= 1'b1;
                if (sidx_reg != 2'h0 || nidx_reg) begin
                    stream_reg <= 1'b0;
                end
            end
        end
    end

    // error and word lines are valid in the done cycle only, elsewhere inverted; listing lines show true values, name data only while valid
    always_comb begin
        chr = (sidx_reg != 2'h0) ? 8'h78 : (nidx_reg ? 8'h62 : 8'h61);
        be_name_valid = stream_reg && (!slow || tick_reg);
        be_name_data = be_name_valid ? chr : ~chr;
        be_path_ready = !slow || tick_reg;
        be_err = be_done ? err_in : ~err_in;
        be_word0 = (be_cmd == 8'h0d) ? TOTAL_BYTES : (be_cmd == 8'h08 ? be_arg : pos_reg);
        be_word1 = (be_cmd == 8'h0d) ? FREE_BYTES : flen_reg;
        if (!be_done) begin
            be_word0 = ~be_word0;
            be_word1 = ~be_word1;
        end
        be_list_end = idx_reg == 2'h2;
        be_list_dir = idx_reg == 2'h0;
        be_name_len = (idx_reg == 2'h0) ? 10'h002 : 10'h001;
    end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
    typedef logic [7:0] fci_bq_t [$];
    logic core_clk, sys_rst, rx_valid, tx_ready, card_present, slow;
    logic [7:0] rx_data, err_in;
    logic [3:0] handle_open;
    logic rx_ready, tx_valid, tx_last, be_req, be_rewind, be_path_valid, be_path_last, be_done;
    logic be_path_ready, be_list_end, be_list_dir, be_name_valid, be_name_ready;
    logic [7:0] tx_data, be_cmd, be_handle, be_path_data, be_err, be_name_data;
    logic [31:0] be_arg, be_word0, be_word1;
    logic [9:0] be_name_len;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;

    fci_file_cmd #(.NUM_HANDLES(4)) u_fci_file_cmd (.core_clk, .sys_rst, .rx_valid, .rx_data,
        .rx_ready, .tx_valid, .tx_data, .tx_last, .tx_ready, .card_present, .handle_open, .be_req,
        .be_cmd, .be_handle, .be_arg, .be_rewind, .be_path_valid, .be_path_data, .be_path_last,
        .be_path_ready, .be_done, .be_err, .be_word0, .be_word1, .be_list_end, .be_list_dir,
        .be_name_len, .be_name_valid, .be_name_data, .be_name_ready);
    fci_backend_model u_fci_backend_model (.core_clk, .sys_rst, .slow, .err_in, .be_req, .be_cmd,
        .be_arg, .be_rewind, .be_path_ready, .be_done, .be_err, .be_word0, .be_word1, .be_list_end,
        .be_list_dir, .be_name_len, .be_name_valid, .be_name_data, .be_name_ready);

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // a hung handshake ends the run here rather than stalling forever
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            final_report;
        end
    end

    task final_report;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (exp !== got) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // sends a whole request, then takes the reply with a sink stall on its first byte
    task xfer(input fci_bq_t req, input fci_bq_t exp);
        int n;
        foreach (req[i]) begin
            @(negedge core_clk);
            rx_valid = 1'b1;
            rx_data = req[i];
            n = 0;
            while (rx_ready !== 1'b1 && n < 2000) begin
                @(negedge core_clk);
                n++;
            end
        end
        @(negedge core_clk);
        rx_valid = 1'b0;
        rx_data = ~rx_data;
        tx_ready = 1'b0;
        foreach (exp[i]) begin
            n = 0;
            @(negedge core_clk);
            while (tx_valid !== 1'b1 && n < 200) begin
                @(negedge core_clk);
                n++;
            end
            check("reply byte", exp[i], tx_data);
            check("last flag", {7'h00, i == exp.size() - 1}, {7'h00, tx_last});
            if (i == 0) begin
                @(negedge core_clk);
                tx_ready = 1'b1;
            end
        end
    endtask

    task t_flush;
        xfer({8'h06, 8'h01, 8'h00, 8'h00}, {8'h86, 8'h01, 8'h00, 8'h00});
        xfer({8'h06, 8'h02, 8'h00, 8'h00}, {8'h7f, 8'h03, 8'h00, 8'h00});
    endtask

    task t_info_seek;
        xfer({8'h07, 8'h01, 8'h00, 8'h00}, {8'h87, 8'h01, 8'h08, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00});
        xfer({8'h08, 8'h01, 8'h04, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00},
            {8'h88, 8'h01, 8'h04, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00});
        slow = 1'b1;
        xfer({8'h07, 8'h01, 8'h00, 8'h00}, {8'h87, 8'h01, 8'h08, 8'h00,
            8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00});
        slow = 1'b0;
    endtask

    task t_paths;
        fci_bq_t q;
        xfer({8'h09, 8'h00, 8'h02, 8'h00, 8'h61, 8'h00}, {8'h89, 8'h00, 8'h00, 8'h00});
        err_in = 8'h02;
        xfer({8'h09, 8'h00, 8'h02, 8'h00, 8'h61, 8'h00}, {8'h7f, 8'h02, 8'h00, 8'h00});
        err_in = 8'h00;
        xfer({8'h09, 8'h00, 8'h00, 8'h00}, {8'h7f, 8'h0f, 8'h00, 8'h00});
        q = {8'h0a, 8'h00, 8'h01, 8'h02};
        repeat (513) q.push_back(8'h41);
        xfer(q, {8'h7f, 8'h0f, 8'h00, 8'h00});
        xfer({8'h0a, 8'h00, 8'h02, 8'h00, 8'h62, 8'h00}, {8'h8a, 8'h00, 8'h00, 8'h00});
    endtask

    task t_list;
        xfer({8'h0b, 8'h00, 8'h00, 8'h00}, {8'h8b, 8'h00, 8'h00, 8'h00});
        slow = 1'b1;
        xfer({8'h0b, 8'h00, 8'h02, 8'h00, 8'h2f, 8'h00},
            {8'h8b, 8'h00, 8'h05, 8'h00, 8'h3c, 8'h61, 8'h62, 8'h3e, 8'h00});
        slow = 1'b0;
        xfer({8'h0b, 8'h00, 8'h02, 8'h00, 8'h2f, 8'h00},
            {8'h8b, 8'h00, 8'h02, 8'h00, 8'h78, 8'h00});
        xfer({8'h0b, 8'h00, 8'h02, 8'h00, 8'h2f, 8'h00}, {8'h8b, 8'h00, 8'h00, 8'h00});
        xfer({8'h0b, 8'h00, 8'h00, 8'h00}, {8'h8b, 8'h00, 8'h00, 8'h00});
        xfer({8'h0b, 8'h00, 8'h02, 8'h00, 8'h2f, 8'h00},
            {8'h8b, 8'h00, 8'h05, 8'h00, 8'h3c, 8'h61, 8'h62, 8'h3e, 8'h00});
    endtask

    task t_card_cap;
        xfer({8'h0c, 8'h00, 8'h00, 8'h00}, {8'h8c, 8'h00, 8'h01, 8'h00, 8'h01});
        xfer({8'h0d, 8'h00, 8'h00, 8'h00}, {8'h8d, 8'h00, 8'h08, 8'h00,
            8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00});
        xfer({8'h0e, 8'h00, 8'h00, 8'h00}, {8'h7f, 8'h13, 8'h00, 8'h00});
        card_present = 1'b0;
        xfer({8'h0c, 8'h00, 8'h00, 8'h00}, {8'h8c, 8'h00, 8'h01, 8'h00, 8'h00});
        xfer({8'h06, 8'h01, 8'h00, 8'h00}, {8'h7f, 8'h11, 8'h00, 8'h00});
        card_present = 1'b1;
    endtask

    initial begin
        sys_rst = 1'b1;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b1;
        card_present = 1'b1;
        handle_open = 4'h3;
        slow = 1'b0;
        err_in = 8'h00;
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 1'b0;
        t_flush;
        t_info_seek;
        t_paths;
        t_list;
        t_card_cap;
        final_report;
    end
endmodule
